/* File: bench/mmd_core_model.sv */
/*
  Core-side model: makes the two candidate output-enable sources.
  Assumes one clock shared with the decoder.
*/
`timescale 1ns/10ps
module mmd_core_model (
  input  wire logic mclk_i,
  output      logic rd_strobe_n_o,
  output      logic rw_signal_o
);
  // ****************************************************************
  // Strobe patterns
  // ****************************************************************
  // Patterns differ in half the cycles, so a wrong source shows quickly
  logic [1:0] cnt = 2'h0;
  always_ff @(posedge mclk_i) begin
    cnt <= cnt + 2'h1;
  end
  assign rd_strobe_n_o = cnt[0];
  assign rw_signal_o   = cnt[1];
endmodule : mmd_core_model

/* File: bench/mmd_memory_map_assertions.sv */
/*
  Checker for the memory map decoder, bound to its top module.
  Assumes status bits are the registered copy on the status port.
*/
`timescale 1ns/10ps
module mmd_memory_map_assertions
  import mmd_pkg::*;
(
  input wire logic                    mclk_i,
  input wire logic                    rst_i,
  input wire logic                    ce_i,
  input wire logic                    cpu_req_i,
  input wire mmd_pkg::mmd_space_type  cpu_space_i,
  input wire logic [15:0]             cpu_addr_i,
  input wire logic                    rd_strobe_n_i,
  input wire logic                    rw_signal_i,
  input wire mmd_pkg::mmd_target_type target_o,
  input wire logic [14:0]             local_addr_o,
  input wire logic [2:0]              wait_states_o,
  input wire logic                    ext_oe_n_o,
  input wire logic [15:0]             program_memory_status_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i || !ce_i);
  wire       cfg = program_memory_status_o[BLOCK_CFG_BIT];
  wire       pa  = cpu_req_i && cpu_space_i == MMD_SP_PROG;
  wire       da  = cpu_req_i && cpu_space_i == MMD_SP_DATA;
  wire       ia  = cpu_req_i && cpu_space_i == MMD_SP_IO;
  wire [7:0] lo  = cpu_addr_i[7:0];

  chk_wait_outside_ext: assert property (!$past(rst_i) && target_o != MMD_T_EXT |->
    wait_states_o == 3'h0)
    else $error("wait states given to on-chip target");
  chk_oe_source_sel: assert property (!$past(rst_i) |-> ext_oe_n_o ==
    (program_memory_status_o[FAST_READ_BIT] ? $past(rw_signal_i) : $past(rd_strobe_n_i)))
    else $error("output enable from wrong source");
  chk_status_after_rst: assert property ($fell(rst_i) |=> program_memory_status_o[15:1] == 15'h000C)
    else $error("status bits wrong after reset");
  chk_flash_mode_map: assert property (pa && cpu_addr_i <= FLASH_END |=> target_o ==
    (program_memory_status_o[MODE_BIT] ? MMD_T_EXT :
     $past(cpu_addr_i[14]) ? MMD_T_FLASH1 : MMD_T_FLASH0)) else $error("low program decode wrong");
  chk_sram_prog_map: assert property (pa && cpu_addr_i inside {[SRAM_PROG_BASE:SRAM_PROG_END]} |=>
    target_o == (program_memory_status_o[SRAM_PROG_BIT] ? MMD_T_SRAM : MMD_T_EXT))
    else $error("program ram window wrong");
  chk_sram_data_map: assert property (da && cpu_addr_i inside {[SRAM_DATA_BASE:SRAM_DATA_END]} |=>
    target_o == (program_memory_status_o[SRAM_DATA_BIT] ? MMD_T_SRAM : MMD_T_EXT))
    else $error("data ram window wrong");
  chk_b0_prog_alias: assert property (pa && cpu_addr_i >= B0_PROG_BASE |=> !cfg ||
    (target_o == MMD_T_B0 && local_addr_o == {7'h00, $past(lo)}))
    else $error("block zero alias wrong");
  chk_b0_prog_ext: assert property (pa && cpu_addr_i >= B0_PROG_BASE |=>
    cfg || target_o == MMD_T_EXT) else $error("top program page not external");
  chk_b0_data_alias: assert property (da && cpu_addr_i inside {[B0_DATA_LO:B0_DATA_HI]} |=>
    cfg || (target_o == MMD_T_B0 && local_addr_o == {7'h00, $past(lo)}))
    else $error("data block zero alias wrong");
  chk_b1_data_alias: assert property (da && cpu_addr_i inside {[B1_DATA_LO:B1_DATA_HI]} |=>
    target_o == MMD_T_B1 && local_addr_o == {7'h00, $past(lo)}) else $error("block one alias wrong");
  chk_io_space_map: assert property (ia |=> target_o == ($past(cpu_addr_i) >= IO_PERIPH_BASE ?
    MMD_T_PERIPH : $past(cpu_addr_i) >= IO_RSV_BASE ? MMD_T_RSV : MMD_T_EXT))
    else $error("io decode wrong");

  cov_b0_prog: cover property (pa && cfg && cpu_addr_i >= B0_PROG_BASE);
  cov_fast_read: cover property (program_memory_status_o[FAST_READ_BIT]);
  cov_flash_one: cover property (target_o == MMD_T_FLASH1);
endmodule : mmd_memory_map_assertions

bind mmd_memory_map mmd_memory_map_assertions u_mmd_memory_map_assertions (.mclk_i, .rst_i, .ce_i,
  .cpu_req_i, .cpu_space_i, .cpu_addr_i, .rd_strobe_n_i, .rw_signal_i, .target_o,
  .local_addr_o, .wait_states_o, .ext_oe_n_o, .program_memory_status_o);

/* File: bench/tb.sv */
/*
  Self-checking bench: register accesses over Avalon-MM and core decodes.
  Assumes the checker binds itself and the core model drives the strobes.
*/
`timescale 1ns/10ps
module tb;
  import mmd_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam logic [14:0] ALL = 15'h7FFF;
  logic           mclk_i, rst_i, mode_pin_i, avs_read_i, avs_write_i, cpu_req_i, cpu_wr_i;
  logic           avs_waitrequest_o, rd_strobe_n_i, rw_signal_i, ext_oe_n_o;
  logic [3:0]     avs_address_i;
  logic [31:0]    avs_writedata_i, avs_readdata_o, q;
  logic [15:0]    cpu_addr_i, cpu_wdata_i, program_memory_status_o;
  logic [14:0]    local_addr_o;
  logic [2:0]     wait_states_o, ws;
  mmd_space_type  cpu_space_i;
  mmd_target_type target_o;
  int             miscompares, n_checks;

  mmd_core_model u_mmd_core_model (.mclk_i, .rd_strobe_n_o(rd_strobe_n_i), .rw_signal_o(rw_signal_i));
  mmd_memory_map u_mmd_memory_map (.mclk_i, .rst_i, .ce_i(1'b1), .mode_pin_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o,
    .avs_waitrequest_o, .cpu_req_i, .cpu_space_i, .cpu_addr_i, .cpu_wr_i,
    .cpu_wdata_i, .rd_strobe_n_i, .rw_signal_i, .target_o, .local_addr_o,
    .wait_states_o, .ext_oe_n_o, .program_memory_status_o);

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge mclk_i);
    end
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask : bus

  task automatic core_wr(input logic [15:0] d);
    cpu_req_i   <= 1'b1;
    cpu_space_i <= MMD_SP_IO;
    cpu_addr_i  <= PMS_IO_ADDR;
    cpu_wr_i    <= 1'b1;
    cpu_wdata_i <= d;
    @(posedge mclk_i);
    cpu_wr_i    <= 1'b0;
    @(posedge mclk_i);
  endtask : core_wr

  task automatic acc(input mmd_space_type s, input logic [15:0] a, input mmd_target_type t,
                     input logic [14:0] l, input logic [14:0] m);
    cpu_req_i   <= 1'b1;
    cpu_space_i <= s;
    cpu_addr_i  <= a;
    @(posedge mclk_i);
    @(posedge mclk_i);
    cmp(target_o, t);
    cmp(local_addr_o & m, l & m);
    cmp(wait_states_o, (t == MMD_T_EXT) ? ws : 3'h0);
  endtask : acc

  task automatic oe_chk(input logic f);
    logic e;
    @(posedge mclk_i);
    e = f ? rw_signal_i : rd_strobe_n_i;
    repeat (4) begin
      @(posedge mclk_i);
      cmp(ext_oe_n_o, e);
      e = f ? rw_signal_i : rd_strobe_n_i;
    end
  endtask : oe_chk

  task automatic after_reset();
    ws = 3'h7;
    bus(1'b0, REG_PMS_OFS, 32'h0);
    cmp(q, 32'h0000_0019);
    bus(1'b0, REG_WAIT_OFS, 32'h0);
    cmp(q, 32'h0000_0007);
  endtask : after_reset

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Clock, watchdog and sequence
  // ****************************************************************
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Whole sequence needs about a hundred cycles
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end

  initial begin
    {rst_i, mode_pin_i, avs_read_i, avs_write_i, cpu_req_i} = 5'b11000;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    cpu_space_i = MMD_SP_PROG;
    cpu_addr_i = 16'h0000;
    cpu_wr_i = 1'b0;
    cpu_wdata_i = 16'h0000;
    miscompares = 0;
    n_checks = 0;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    after_reset();
    bus(1'b0, 4'hC, 32'h0);
    cmp(q, 32'h0);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    acc(MMD_SP_PROG, 16'h0005, MMD_T_EXT, 15'h0005, ALL);
    acc(MMD_SP_IO, 16'hFF20, MMD_T_PERIPH, 15'h0, 15'h0);
    acc(MMD_SP_IO, 16'hFF05, MMD_T_RSV, 15'h0, 15'h0);
    acc(MMD_SP_IO, 16'h0010, MMD_T_EXT, 15'h0010, ALL);
    acc(MMD_SP_DATA, 16'h0105, MMD_T_B0, 15'h0005, ALL);
    acc(MMD_SP_DATA, 16'h0205, MMD_T_B0, 15'h0005, ALL);
    acc(MMD_SP_DATA, 16'h0307, MMD_T_B1, 15'h0007, ALL);
    acc(MMD_SP_DATA, 16'h0407, MMD_T_B1, 15'h0007, ALL);
    acc(MMD_SP_PROG, 16'hFF05, MMD_T_EXT, 15'h0005, ALL);
    bus(1'b0, REG_STAT_OFS, 32'h0);
    cmp(q, 32'h0000_0007);
    acc(MMD_SP_PROG, 16'h8010, MMD_T_SRAM, 15'h0010, ALL);
    acc(MMD_SP_DATA, 16'h0810, MMD_T_SRAM, 15'h0010, ALL);
    oe_chk(1'b0);
    bus(1'b1, REG_PMS_OFS, 32'h0000_0004);
    bus(1'b0, REG_PMS_OFS, 32'h0);
    cmp(q, 32'h0000_0004);
    acc(MMD_SP_PROG, 16'h0005, MMD_T_FLASH0, 15'h0005, ALL);
    acc(MMD_SP_PROG, 16'h4003, MMD_T_FLASH1, 15'h0, 15'h0);
    acc(MMD_SP_PROG, 16'hFE05, MMD_T_B0, 15'h0005, ALL);
    acc(MMD_SP_PROG, 16'hFF05, MMD_T_B0, 15'h0005, ALL);
    acc(MMD_SP_PROG, 16'h8010, MMD_T_EXT, 15'h0010, ALL);
    acc(MMD_SP_DATA, 16'h0810, MMD_T_EXT, 15'h0010, ALL);
    acc(MMD_SP_DATA, 16'h0105, MMD_T_RSV, 15'h0, 15'h0);
    bus(1'b1, REG_PMS_OFS, 32'h0000_8018);
    bus(1'b0, REG_PMS_OFS, 32'h0);
    cmp(q, 32'h0000_8018);
    oe_chk(1'b1);
    bus(1'b1, REG_WAIT_OFS, 32'h0000_0003);
    ws = 3'h3;
    acc(MMD_SP_PROG, 16'h9000, MMD_T_EXT, 15'h1000, ALL);
    core_wr(16'h0001);
    bus(1'b0, REG_PMS_OFS, 32'h0);
    cmp(q, 32'h0000_0001);
    acc(MMD_SP_PROG, 16'h0005, MMD_T_EXT, 15'h0005, ALL);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    after_reset();
    acc(MMD_SP_PROG, 16'h9000, MMD_T_EXT, 15'h1000, ALL);
    finish_test();
  end
endmodule : tb

/* File: design/mmd_decode.sv */
/*
  Combinational address decoder: steers one processor access to its target.
  Assumes the configuration bits are stable flops from the register block.
*/
`timescale 1ns/10ps
module mmd_decode (
  input  wire mmd_pkg::mmd_space_type  space_i,
  input  wire logic [15:0]             addr_i,
  input  wire logic                    micro_mode_i,
  input  wire logic                    block_cfg_i,
  input  wire logic                    sram_prog_en_i,
  input  wire logic                    sram_data_en_i,
  output      mmd_pkg::mmd_target_type target_o,
  output      logic [14:0]             local_addr_o
);
  import mmd_pkg::*;

  function automatic logic in_range(input logic [15:0] a, lo, hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  always_comb begin
    target_o     = MMD_T_EXT;
    local_addr_o = addr_i[14:0];
    case (space_i)
      MMD_SP_PROG: begin
        if (addr_i <= FLASH_END) begin
          if (!micro_mode_i) begin
            target_o = addr_i[14] ? MMD_T_FLASH1 : MMD_T_FLASH0;
          end
        end else if (in_range(addr_i, SRAM_PROG_BASE, SRAM_PROG_END)) begin
          if (sram_prog_en_i) begin
            target_o = MMD_T_SRAM;
          end
          local_addr_o = {3'h0, addr_i[11:0]};
        end else if (addr_i >= B0_PROG_BASE) begin
          if (block_cfg_i) begin
            target_o = MMD_T_B0;
          end
          local_addr_o = {7'h00, addr_i[7:0]};
        end
      end
      MMD_SP_DATA: begin
        if (in_range(addr_i, B2_DATA_LO, B2_DATA_HI)) begin
          target_o     = MMD_T_B2;
          local_addr_o = {10'h000, addr_i[4:0]};
        end else if (in_range(addr_i, B0_DATA_LO, B0_DATA_HI)) begin
          target_o     = block_cfg_i ? MMD_T_RSV : MMD_T_B0;
          local_addr_o = {7'h00, addr_i[7:0]};
        end else if (in_range(addr_i, B1_DATA_LO, B1_DATA_HI)) begin
          target_o     = MMD_T_B1;
          local_addr_o = {7'h00, addr_i[7:0]};
        end else if (addr_i < SRAM_DATA_BASE) begin
          target_o = MMD_T_RSV;
        end else if (addr_i <= SRAM_DATA_END) begin
          if (sram_data_en_i) begin
            target_o = MMD_T_SRAM;
          end
          local_addr_o = 15'(addr_i - SRAM_DATA_BASE);
        end
      end
      MMD_SP_IO: begin
        if (addr_i >= IO_PERIPH_BASE) begin
          target_o = MMD_T_PERIPH;
        end else if (addr_i >= IO_RSV_BASE) begin
          target_o = MMD_T_RSV;
        end
      end
      default: target_o = MMD_T_NONE;
    endcase
  end

endmodule : mmd_decode

/* File: design/mmd_memory_map.sv */
/*
  Memory map decode and read strobe select for a 16-bit signal processor.
  Holds the program memory status register, a wait-state register and a
  registered decode result. Assumes the core presents one access at a time
  and the mode pin arrives asynchronously from a board pin.
*/
// Implementation choice: the Avalon-MM slave port.
// Functional notes
// - Two 16K flash halves form 32K program array
// - Flash reads insert no wait states
// - Config 1: FE00 and FF00 alias block zero
// - Config 0: data 0100 and 0200 alias block zero
// - Data 0300 and 0400 always alias block one
// - Status bit 15 picks read/write as strobe
// - Normal read strobe selected after reset
// - Maximum external wait states after reset
// - Mode pin latched to bit 0; 1 external
// - Two enables map 4K RAM, reset both 1
`timescale 1ns/10ps
module mmd_memory_map (
  input  wire  logic                    mclk_i,
  input  wire  logic                    rst_i,
  input  wire  logic                    ce_i,
  input  wire  logic                    mode_pin_i,
  input  wire  logic [3:0]              avs_address_i,
  input  wire  logic                    avs_read_i,
  input  wire  logic                    avs_write_i,
  input  wire  logic [31:0]             avs_writedata_i,
  input  wire  logic [3:0]              avs_byteenable_i,
  output       logic [31:0]             avs_readdata_o,
  output       logic                    avs_waitrequest_o,
  input  wire  logic                    cpu_req_i,
  input  wire  mmd_pkg::mmd_space_type  cpu_space_i,
  input  wire  logic [15:0]             cpu_addr_i,
  input  wire  logic                    cpu_wr_i,
  input  wire  logic [15:0]             cpu_wdata_i,
  input  wire  logic                    rd_strobe_n_i,
  input  wire  logic                    rw_signal_i,
  output       mmd_pkg::mmd_target_type target_o,
  output       logic [14:0]             local_addr_o,
  output       logic [2:0]              wait_states_o,
  output       logic                    ext_oe_n_o,
  output       logic [15:0]             program_memory_status_o
);
  import mmd_pkg::*;

  // ****************************************************************
  // Mode pin synchroniser
  // ****************************************************************
  logic mode_meta;
  logic mode_sync;
  logic mode_captured;

  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      mode_meta <= mode_pin_i;
      mode_sync <= mode_meta;
    end
  end

  // ****************************************************************
  // Configuration state
  // ****************************************************************
  logic        fast_read_select;
  logic        block_zero_space_config;
  logic        sram_in_program_enable;
  logic        sram_in_data_enable;
  logic        processor_or_microcomputer_mode;
  logic [2:0]  ext_wait_states;
  logic        bus_pms_wr;
  logic        bus_wait_wr;
  logic        core_pms_wr;
  logic [15:0] pms_value;

  // A write lands only in its answer cycle, when waitrequest is low
  function automatic logic bus_wr_hit(input logic       wr,
                                      input logic       busy,
                                      input logic [3:0] adr,
                                      input logic [3:0] ofs);
    bus_wr_hit = wr && !busy && (adr == ofs);
  endfunction : bus_wr_hit

  assign bus_pms_wr  = bus_wr_hit(avs_write_i, avs_waitrequest_o, avs_address_i, REG_PMS_OFS);
  assign bus_wait_wr = bus_wr_hit(avs_write_i, avs_waitrequest_o, avs_address_i, REG_WAIT_OFS)
                       && avs_byteenable_i[0];
  assign core_pms_wr = cpu_req_i && cpu_wr_i && cpu_space_i == MMD_SP_IO
                       && cpu_addr_i == PMS_IO_ADDR;

  function automatic logic [15:0] pms_word(input logic f, c, d, p, m);
    pms_word = 16'h0000;
    pms_word[FAST_READ_BIT] = f;
    pms_word[BLOCK_CFG_BIT] = c;
    pms_word[SRAM_DATA_BIT] = d;
    pms_word[SRAM_PROG_BIT] = p;
    pms_word[MODE_BIT]      = m;
  endfunction : pms_word

  assign pms_value = pms_word(fast_read_select, block_zero_space_config,
                              sram_in_data_enable, sram_in_program_enable,
                              processor_or_microcomputer_mode);

  // ****************************************************************
  // Mode bit capture
  // ****************************************************************
  // Mode bit is captured from the pin once, after reset release;
  // the pin must settle two edges before release or the guess is stale
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      processor_or_microcomputer_mode <= 1'b1;
      mode_captured                   <= 1'b0;
    end else if (ce_i) begin
      if (!mode_captured) begin
        processor_or_microcomputer_mode <= mode_sync;
        mode_captured                   <= 1'b1;
      end else if (core_pms_wr) begin
        processor_or_microcomputer_mode <= cpu_wdata_i[MODE_BIT];
      end else if (bus_pms_wr && avs_byteenable_i[0]) begin
        processor_or_microcomputer_mode <= avs_writedata_i[MODE_BIT];
      end
    end
  end

  // ****************************************************************
  // Status control bits
  // ****************************************************************
  // Core write takes priority when both ports write in one cycle
  // Bits with no field here read zero and drop writes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fast_read_select        <= FAST_READ_RST;
      block_zero_space_config <= BLOCK_CFG_RST;
      sram_in_program_enable  <= SRAM_EN_RST;
      sram_in_data_enable     <= SRAM_EN_RST;
    end else if (ce_i) begin
      if (core_pms_wr) begin
        fast_read_select        <= cpu_wdata_i[FAST_READ_BIT];
        block_zero_space_config <= cpu_wdata_i[BLOCK_CFG_BIT];
        sram_in_program_enable  <= cpu_wdata_i[SRAM_PROG_BIT];
        sram_in_data_enable     <= cpu_wdata_i[SRAM_DATA_BIT];
      end else if (bus_pms_wr) begin
        if (avs_byteenable_i[1]) begin
          fast_read_select <= avs_writedata_i[FAST_READ_BIT];
        end
        if (avs_byteenable_i[0]) begin
          block_zero_space_config <= avs_writedata_i[BLOCK_CFG_BIT];
          sram_in_program_enable  <= avs_writedata_i[SRAM_PROG_BIT];
          sram_in_data_enable     <= avs_writedata_i[SRAM_DATA_BIT];
        end
      end
    end
  end

  // ****************************************************************
  // External wait-state register
  // ****************************************************************
  // Starts at the slowest setting so any external part answers in time
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ext_wait_states <= WAIT_STATES_MAX;
    end else if (ce_i && bus_wait_wr) begin
      ext_wait_states <= avs_writedata_i[2:0];
    end
  end

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  logic [31:0] next_readdata;

  // Unmapped offsets read zero; the status word fills the low half only
  always_comb begin
    case (avs_address_i)
      REG_PMS_OFS:  next_readdata = {16'h0000, pms_value};
      REG_WAIT_OFS: next_readdata = {29'h0, ext_wait_states};
      REG_STAT_OFS: next_readdata = {28'h0, target_o};
      default:      next_readdata = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Avalon slave: one wait cycle, then answer
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else if (ce_i) begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      // Data is caught in the wait cycle so it stands when waitrequest drops
      if (avs_read_i && avs_waitrequest_o) begin
        avs_readdata_o <= next_readdata;
      end
    end
  end

  // ****************************************************************
  // Registered decode and strobes
  // ****************************************************************
  mmd_target_type dec_target;
  logic [14:0]    dec_local;

  mmd_decode u_decode (
    .space_i        (cpu_space_i),
    .addr_i         (cpu_addr_i),
    .micro_mode_i   (processor_or_microcomputer_mode),
    .block_cfg_i    (block_zero_space_config),
    .sram_prog_en_i (sram_in_program_enable),
    .sram_data_en_i (sram_in_data_enable),
    .target_o       (dec_target),
    .local_addr_o   (dec_local)
  );

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      target_o                <= MMD_T_NONE;
      local_addr_o            <= 15'h0000;
      wait_states_o           <= WAIT_STATES_MAX;
      ext_oe_n_o              <= 1'b1;
      program_memory_status_o <= 16'h0000;
    end else if (ce_i) begin
      target_o                <= cpu_req_i ? dec_target : MMD_T_NONE;
      local_addr_o            <= dec_local;
      program_memory_status_o <= pms_value;
      // Only external accesses stretch; flash and RAM run at full speed
      wait_states_o <= (cpu_req_i && dec_target == MMD_T_EXT)
                       ? ext_wait_states : 3'h0;
      // Read/write line is faster but asserts low only for writes
      ext_oe_n_o <= fast_read_select ? rw_signal_i : rd_strobe_n_i;
    end
  end

endmodule : mmd_memory_map

/* File: shared/mmd_pkg.sv */
/*
  Shared constants and types for the memory-map decoder and its
  software-visible configuration register.
  Assumes a 16-bit processor address space and a 32-bit Avalon-MM register port.
*/
package mmd_pkg;

  // ****************************************************************
  // Register map (core I/O address, then byte addresses on the Avalon port)
  // ****************************************************************
  localparam logic [15:0] PMS_IO_ADDR      = 16'hFFE4;
  localparam logic [3:0]  REG_PMS_OFS      = 4'h0;
  localparam logic [3:0]  REG_WAIT_OFS     = 4'h4;
  localparam logic [3:0]  REG_STAT_OFS     = 4'h8;

  // ****************************************************************
  // Field positions of the program memory status register
  // ****************************************************************
  localparam int          FAST_READ_BIT    = 15;
  localparam int          BLOCK_CFG_BIT    = 2;
  localparam int          SRAM_DATA_BIT    = 3;
  localparam int          SRAM_PROG_BIT    = 4;
  localparam int          MODE_BIT         = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        FAST_READ_RST    = 1'b0;
  localparam logic        BLOCK_CFG_RST    = 1'b0;
  localparam logic        SRAM_EN_RST      = 1'b1;
  localparam logic [2:0]  WAIT_STATES_MAX  = 3'h7;

  // ****************************************************************
  // Address windows
  // ****************************************************************
  localparam logic [15:0] FLASH_END        = 16'h7FFF;
  localparam logic [15:0] SRAM_PROG_BASE   = 16'h8000;
  localparam logic [15:0] SRAM_PROG_END    = 16'h8FFF;
  localparam logic [15:0] B0_PROG_BASE     = 16'hFE00;
  localparam logic [15:0] B0_DATA_LO       = 16'h0100;
  localparam logic [15:0] B0_DATA_HI       = 16'h02FF;
  localparam logic [15:0] B1_DATA_LO       = 16'h0300;
  localparam logic [15:0] B1_DATA_HI       = 16'h04FF;
  localparam logic [15:0] B2_DATA_LO       = 16'h0060;
  localparam logic [15:0] B2_DATA_HI       = 16'h007F;
  localparam logic [15:0] SRAM_DATA_BASE   = 16'h0800;
  localparam logic [15:0] SRAM_DATA_END    = 16'h17FF;
  localparam logic [15:0] IO_RSV_BASE      = 16'hFF00;
  localparam logic [15:0] IO_PERIPH_BASE   = 16'hFF10;

  typedef enum logic [1:0] {
    MMD_SP_PROG,
    MMD_SP_DATA,
    MMD_SP_IO
  } mmd_space_type;

  typedef enum logic [3:0] {
    MMD_T_NONE,
    MMD_T_FLASH0,
    MMD_T_FLASH1,
    MMD_T_B0,
    MMD_T_B1,
    MMD_T_B2,
    MMD_T_SRAM,
    MMD_T_EXT,
    MMD_T_PERIPH,
    MMD_T_RSV
  } mmd_target_type;

endpackage : mmd_pkg
